//--- rtl/ibc_pkg.sv
// Constants, state codes and carrier structs for the bus-condition block.
// Assumes a 250 MHz core clock and open-drain lines resolved outside.
// How it works
// [RULE1] Start is data falling while clock stays high.
// [RULE2] Only a master issues Start; it moves the bus from Idle to Active.
// [RULE3] Bus is Idle when no master owns it and both lines are high.
// [RULE4] Stop is data rising while clock stays high.
// [RULE5] Stop counts only after a clock-low period since the Start.
// [RULE6] Restart is accepted exactly where a Stop would be accepted.
// [RULE7] Restart resets slave logic like Start and awaits a new address.
// [RULE8] Master reading a 10-bit slave first matches both bytes as write, then restarts.
// [RULE9] After full 10-bit match, restart and read header, hold clock low, fetch data.
// [RULE10] Hold select stretches data hold after clock fall to at least 300 ns.
// [RULE11] Collision flagged when data reads low while we output high.
// [RULE12] Address matches only when equal to the slave address setting.
// [RULE13] Match with write bit enters write request, ready for data bytes.
// [RULE14] After read request, supply every byte until Restart or Stop; the code stops supplying after a master NACK.
// [RULE15] Anyone may stall by holding clock low; others wait for release.
// [RULE16] Each unit is nine clocks: eight data bits MSB first, then acknowledge.
// [RULE17] Data changes only while clock low; sampled on clock rise.
// [RULE18] 10-bit first byte compares against 11110, two top address bits, zero.
// [RULE19] Clock and data inputs are synchronised before edge detection.
// [RULE20] Start, Stop and collision events are reported as status outputs.

package ibc_pkg;

    // Timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int HOLD_LONG_NS    = 300;
    localparam int HOLD_SHORT_NS   = 100;
    localparam int HOLD_LONG_CYC   = (HOLD_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_SHORT_CYC  = (HOLD_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_W          = 7;

    // Byte framing
    localparam logic [3:0] LAST_DATA_CNT = 4'h7;
    localparam logic [3:0] ACK_CNT       = 4'h8;
    localparam logic [4:0] TEN_PREFIX    = 5'h1e;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ADDR    = 6'h02,
        ST_ADDR_LO = 6'h04,
        ST_RX      = 6'h08,
        ST_TX      = 6'h10,
        ST_SKIP    = 6'h20
    } ibc_state_t;

    typedef struct packed {
        logic start;
        logic restart;
        logic stop;
        logic collision;
    } ibc_events_t;

    typedef struct packed {
        logic bus_active;
        logic write_req;
        logic read_req;
        logic ten_matched;
    } ibc_status_t;

    typedef struct packed {
        ibc_state_t        state;
        logic              scl_p;
        logic              sda_p;
        logic              low_seen;
        logic [3:0]        bit_cnt;
        logic [7:0]        shreg;
        logic [7:0]        tx_shift;
        logic              master_nack;
        logic [HOLD_W-1:0] hold_cnt;
        logic              sda_pend;
        logic              sda_oe;
        logic              scl_oe;
        logic              line_lvl;
        logic              tx_req;
        ibc_events_t       ev;
        ibc_status_t       st;
        logic [7:0]        rx_byte;
        logic              rx_valid;
    } ibc_core_t;

    localparam ibc_core_t CORE_RESET = '{state: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1,
                                          default: '0};

endpackage : ibc_pkg

//--- rtl/ibc_sync2.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes lines idle high, so both stages reset to one.
`timescale 1ns/10ps
`default_nettype none

module ibc_sync2 #(
    parameter int W = 2
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);

    logic [W-1:0] meta_q;

    // Width check
    initial begin
        if (W < 1) begin
            $error("ibc_sync2: W must be at least 1");
        end
    end

    // First stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '1;
            o_sync <= '1;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule // ibc_sync2

`default_nettype wire

//--- rtl/ibc_bus_cond.sv
// Bus-condition detector and slave address/transfer engine for a two-wire port.
// Assumes open-drain resolution outside; pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none

module ibc_bus_cond (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_scl_i,
    output var  logic                 o_scl_o,
    output var  logic                 o_scl_oe,
    input  wire logic                 i_sda_i,
    output var  logic                 o_sda_o,
    output var  logic                 o_sda_oe,
    input  wire logic [9:0]           i_slave_address_register,
    input  wire logic                 i_ten_bit_mode,
    input  wire logic                 i_data_hold_long_select,
    input  wire logic [7:0]           i_tx_byte,
    input  wire logic                 i_tx_valid,
    output var  logic                 o_tx_request,
    output var  logic [7:0]           o_rx_byte,
    output var  logic                 o_rx_valid,
    output var  ibc_pkg::ibc_events_t o_events,
    output var  ibc_pkg::ibc_status_t o_status
);

    ibc_pkg::ibc_core_t q;
    ibc_pkg::ibc_core_t d;
    logic [1:0]         sync_lines;
    logic               scl_s;
    logic               sda_s;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_c;
    logic               stop_c;
    logic               restart_c;

    // Pin synchroniser
    ibc_sync2 #(.W(2)) u_sync (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    ({i_scl_i, i_sda_i}),
        .o_sync     (sync_lines)
    ); // RULE19

    assign scl_s = sync_lines[1];
    assign sda_s = sync_lines[0];

    // Line events from sampled levels
    assign scl_rise  = scl_s & ~q.scl_p;
    assign scl_fall  = ~scl_s & q.scl_p;
    assign start_c   = scl_s & q.scl_p & q.sda_p & ~sda_s; // RULE1
    assign stop_c    = scl_s & q.scl_p & ~q.sda_p & sda_s & q.low_seen; // RULE4 RULE5
    assign restart_c = start_c & q.st.bus_active & q.low_seen; // RULE6

    // Next-state logic
    always_comb begin
        d          = q;
        d.ev       = '0;
        d.rx_valid = 1'b0;
        d.scl_p    = scl_s;
        d.sda_p    = sda_s;
        d.line_lvl = 1'b0;
        if (!scl_s) begin
            d.low_seen = 1'b1;
        end
        // Delayed data change after clock fall
        if (q.hold_cnt > ibc_pkg::HOLD_W'(1)) begin
            d.hold_cnt = q.hold_cnt - ibc_pkg::HOLD_W'(1); // RULE10
        end else if (q.hold_cnt == ibc_pkg::HOLD_W'(1)) begin
            d.sda_oe   = q.sda_pend; // RULE17
            d.hold_cnt = '0;
        end
        // Data for a read arrives while clock is held low
        if (q.tx_req && i_tx_valid) begin
            d.tx_shift = i_tx_byte;
            d.tx_req   = 1'b0;
            d.scl_oe   = 1'b0; // RULE15
            d.sda_oe   = ~i_tx_byte[7];
            d.hold_cnt = '0;
        end
        if (start_c) begin
            d.ev.restart  = restart_c; // RULE6
            d.ev.start    = ~restart_c; // RULE2 RULE20
            d.st.bus_active = 1'b1;
            d.low_seen    = 1'b0;
            d.state       = ibc_pkg::ST_ADDR; // RULE7
            d.bit_cnt     = '0;
            d.st.write_req = 1'b0;
            d.st.read_req = 1'b0;
            d.sda_oe      = 1'b0;
            d.scl_oe      = 1'b0;
            d.tx_req      = 1'b0;
            d.hold_cnt    = '0;
        end else if (stop_c) begin
            d.ev.stop     = 1'b1; // RULE20
            d.st          = '0; // RULE3
            d.state       = ibc_pkg::ST_IDLE;
            d.sda_oe      = 1'b0;
            d.scl_oe      = 1'b0;
            d.tx_req      = 1'b0;
            d.hold_cnt    = '0;
        end else if (q.state != ibc_pkg::ST_IDLE) begin
            // Sample on rising clock
            if (scl_rise) begin
                if (q.bit_cnt < ibc_pkg::ACK_CNT) begin
                    d.shreg = {q.shreg[6:0], sda_s}; // RULE16 RULE17
                    if (q.state == ibc_pkg::ST_TX && !q.sda_oe && !sda_s) begin
                        d.ev.collision = 1'b1; // RULE11
                        d.state        = ibc_pkg::ST_SKIP;
                        d.hold_cnt     = '0;
                    end
                end else if (q.state == ibc_pkg::ST_TX) begin
                    d.master_nack = sda_s;
                end
            end
            // Advance on falling clock
            if (scl_fall) begin
                d.sda_pend = 1'b0;
                d.hold_cnt = i_data_hold_long_select ?
                             ibc_pkg::HOLD_W'(ibc_pkg::HOLD_LONG_CYC) :
                             ibc_pkg::HOLD_W'(ibc_pkg::HOLD_SHORT_CYC); // RULE10
                if (q.bit_cnt == ibc_pkg::ACK_CNT) begin
                    d.bit_cnt = '0; // RULE16
                    if (q.state == ibc_pkg::ST_TX) begin
                        if (q.master_nack) begin
                            d.state = ibc_pkg::ST_SKIP;
                        end else begin
                            d.scl_oe = 1'b1; // RULE9 RULE14 RULE15
                            d.tx_req = 1'b1;
                        end
                    end
                end else if (q.low_seen) begin // Fall that ends a start is no bit
                    d.bit_cnt = q.bit_cnt + 4'h1;
                    if (q.state == ibc_pkg::ST_TX && q.bit_cnt < ibc_pkg::LAST_DATA_CNT) begin
                        d.sda_pend = ~q.tx_shift[6]; // RULE16
                        d.tx_shift = {q.tx_shift[6:0], 1'b0};
                    end
                    if (q.bit_cnt == ibc_pkg::LAST_DATA_CNT) begin
                        case (q.state)
                            ibc_pkg::ST_ADDR: begin
                                d.state = ibc_pkg::ST_SKIP;
                                if (!i_ten_bit_mode) begin
                                    if (q.shreg[7:1] == i_slave_address_register[6:0]) begin
                                        d.sda_pend = 1'b1; // RULE12
                                        if (q.shreg[0]) begin
                                            d.st.read_req = 1'b1; // RULE14
                                            d.master_nack = 1'b0;
                                            d.state       = ibc_pkg::ST_TX;
                                        end else begin
                                            d.st.write_req = 1'b1; // RULE13
                                            d.state        = ibc_pkg::ST_RX;
                                        end
                                    end
                                end else if (q.shreg[7:1] == {ibc_pkg::TEN_PREFIX,
                                             i_slave_address_register[9:8]}) begin // RULE18
                                    if (!q.shreg[0]) begin
                                        d.sda_pend = 1'b1;
                                        d.state    = ibc_pkg::ST_ADDR_LO;
                                    end else if (q.st.ten_matched) begin
                                        d.sda_pend    = 1'b1; // RULE8 RULE9
                                        d.st.read_req = 1'b1;
                                        d.master_nack = 1'b0;
                                        d.state       = ibc_pkg::ST_TX;
                                    end
                                end
                            end
                            ibc_pkg::ST_ADDR_LO: begin
                                if (q.shreg == i_slave_address_register[7:0]) begin
                                    d.sda_pend       = 1'b1; // RULE12
                                    d.st.ten_matched = 1'b1;
                                    d.st.write_req   = 1'b1; // RULE13
                                    d.state          = ibc_pkg::ST_RX;
                                end else begin
                                    d.state = ibc_pkg::ST_SKIP;
                                end
                            end
                            ibc_pkg::ST_RX: begin
                                d.sda_pend = 1'b1;
                                d.rx_byte  = q.shreg;
                                d.rx_valid = 1'b1;
                            end
                            default: begin
                                d.sda_pend = 1'b0;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= ibc_pkg::CORE_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign o_scl_o      = q.line_lvl;
    assign o_scl_oe     = q.scl_oe;
    assign o_sda_o      = q.line_lvl;
    assign o_sda_oe     = q.sda_oe;
    assign o_tx_request = q.tx_req;
    assign o_rx_byte    = q.rx_byte;
    assign o_rx_valid   = q.rx_valid;
    assign o_events     = q.ev;
    assign o_status     = q.st;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence scl_high_s;
        scl_s && q.scl_p;
    endsequence

    sequence sda_fall_s;
        q.sda_p && !sda_s;
    endsequence

    start_seen_a: assert property (scl_high_s and sda_fall_s |=> o_events.start || o_events.restart) // RULE1
        else $error("start condition missed");
    stop_gated_a: assert property (o_events.stop |-> $past(q.low_seen) && !o_status.bus_active) // RULE5
        else $error("stop without clock low");
    stop_seen_a: assert property (scl_high_s and (!q.sda_p && sda_s && q.low_seen) |=> o_events.stop) // RULE4
        else $error("stop condition missed");
    restart_gate_a: assert property (o_events.restart |-> $past(q.low_seen) && $past(q.st.bus_active)) // RULE6
        else $error("restart accepted where stop would not be");
    restart_reset_a: assert property (o_events.restart |-> q.state == ibc_pkg::ST_ADDR && q.bit_cnt == 4'h0) // RULE7
        else $error("restart did not reset slave");
    collision_a: assert property (o_events.collision |-> $past(!sda_s) && $past(!q.sda_oe) && q.state == ibc_pkg::ST_SKIP) // RULE11
        else $error("collision flagged wrongly");
    hold_load_a: assert property (q.state != ibc_pkg::ST_IDLE && scl_fall && !start_c && !stop_c
        |=> q.hold_cnt == (i_data_hold_long_select ? 7'h4b : 7'h19)) // RULE10
        else $error("hold count wrong");
    hold_steady_a: assert property (q.hold_cnt > 7'h01 && !start_c && !stop_c && !q.tx_req |=> $stable(o_sda_oe)) // RULE10
        else $error("data changed inside hold time");
    addr_match_a: assert property ($rose(o_status.write_req) && !i_ten_bit_mode
        |-> $past(q.shreg[7:1]) == i_slave_address_register[6:0] && q.state == ibc_pkg::ST_RX) // RULE12 RULE13
        else $error("write request without address match");
    read_hold_a: assert property (o_tx_request |-> o_scl_oe && q.state == ibc_pkg::ST_TX) // RULE9
        else $error("read request without clock hold");

endmodule // ibc_bus_cond

`default_nettype wire

//--- verif/ibc_i2c_master.sv
// Behavioural bus master for the two-wire port, open-drain on both lines.
// Assumes the bench resolves each line with a pull-up; times in ns.
`timescale 1ns/10ps
`default_nettype none

module ibc_i2c_master (
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_scl_oe,
    output var  logic o_sda_oe
);
    int   lo_ns     = 140;
    logic stretched = 1'b0;

    // Lines released, clock standing still outside frames
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end

    // Release the clock and wait, bounded, while anyone holds it low
    task automatic rise();
        int k;
        o_scl_oe = 1'b0;
        #1;
        for (k = 0; k < 5000 && i_scl !== 1'b1; k++) #4;
        if (k > 0) stretched = 1'b1;
        #15;
    endtask

    // Start (pre_oe low) or stop (pre_oe high): data moves while clock high
    task automatic cond(input logic pre_oe);
        #24;
        o_sda_oe = pre_oe;
        #(lo_ns - 24);
        rise();
        #16;
        o_sda_oe = ~pre_oe;
        #32;
        if (!pre_oe) o_scl_oe = 1'b1;
    endtask

    // Data pulsed low with the clock high, nothing else: start then stop, no clock low
    task automatic blip();
        o_sda_oe = 1'b1;
        #64;
        o_sda_oe = 1'b0;
        #64;
    endtask

    // Nine clocks, MSB first; a one in d leaves the line free to read
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            #24;
            o_sda_oe = ~d[i];
            #(lo_ns - 24);
            rise();
            r[i] = i_sda;
            #16;
            o_scl_oe = 1'b1;
        end
    endtask
endmodule // ibc_i2c_master

`default_nettype wire

//--- verif/test_i2c_bus_condition_detect.sv
// Self-checking bench for the bus-condition block with a master model.
// Assumes lines pulled up here; design outputs resolved with the model's.
`timescale 1ns/10ps
`default_nettype none

module test_i2c_bus_condition_detect;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic       hl;
        logic       ack;
    } ibc_row_t;

    logic i_core_clk, i_reset_n, tm, hl, tx_valid, ev_clr;
    logic scl_o, scl_oe, sda_o, sda_oe, tx_req, rx_valid, oe_q, m_scl, m_sda;
    logic [9:0] sa;
    logic [7:0] tx_byte, rx_byte, low_cnt, hold_meas;
    logic [6:0] stall = 7'h00;
    logic       rx_hit = 1'b0;
    logic [3:0] ev_seen = 4'h0;
    logic [8:0] got;
    ibc_pkg::ibc_events_t ev;
    ibc_pkg::ibc_status_t st;
    int fails = 0, tests_run = 0, cyc = 0;
    wire scl_line, sda_line;
    ibc_row_t rows [3] = '{'{7'h2a, 8'ha5, 1'b1, 1'b0}, '{7'h2b, 8'h3c, 1'b0, 1'b1},
                           '{7'h2a, 8'h01, 1'b0, 1'b0}};

    // Open-drain lines with pull-ups
    assign scl_line = (scl_oe ? scl_o : 1'b1) & ~m_scl;
    assign sda_line = (sda_oe ? sda_o : 1'b1) & ~m_sda;

    ibc_bus_cond dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_scl_i(scl_line),
        .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda_i(sda_line), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_slave_address_register(sa), .i_ten_bit_mode(tm),
        .i_data_hold_long_select(hl), .i_tx_byte(tx_byte), .i_tx_valid(tx_valid),
        .o_tx_request(tx_req), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid),
        .o_events(ev), .o_status(st));

    ibc_i2c_master m (.i_scl(scl_line), .i_sda(sda_line), .o_scl_oe(m_scl), .o_sda_oe(m_sda));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // Hold meter, event catcher, data server and run limit
    always @(posedge i_core_clk) begin
        low_cnt <= scl_line ? 8'h00 : low_cnt + 8'h01;
        if (sda_oe && !oe_q) hold_meas <= low_cnt;
        oe_q <= sda_oe;
        ev_seen <= ev_clr ? 4'h0 : ev_seen | ev;
        rx_hit <= ev_clr ? 1'b0 : rx_hit | rx_valid;
        stall <= tx_req ? stall + 7'h01 : 7'h00;
        tx_valid <= tx_req && stall == 7'h40; // Late enough that the master meets the hold
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic clr_ev();
        @(posedge i_core_clk);
        ev_clr <= 1'b1;
        @(posedge i_core_clk);
        ev_clr <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Start, address, one data byte, stop
    task automatic run_row(input ibc_row_t r);
        @(posedge i_core_clk);
        hl <= r.hl;
        m.lo_ns = r.hl ? 340 : 140;
        clr_ev();
        m.cond(1'b0);
        m.xfer({r.addr, 1'b0, 1'b1}, got);
        chk(got[0], r.ack);
        if (!r.ack) begin
            chk(st.write_req, 1'b1);
            chk(hold_meas >= (r.hl ? 75 : ibc_pkg::HOLD_SHORT_CYC) && hold_meas < (r.hl ? 200 : 75),
                1'b1);
        end
        m.xfer({r.data, 1'b1}, got);
        chk(rx_hit, !r.ack);
        if (!r.ack) chk(rx_byte, r.data);
        m.cond(1'b1);
        chk(ev_seen, 4'ha);
        chk(st, 4'h0);
    endtask

    // Read by 7-bit address; the master's own data bits may override
    task automatic read7(input logic [7:0] mdata, input logic [7:0] exp);
        clr_ev();
        m.cond(1'b0);
        m.xfer({7'h2a, 1'b1, 1'b1}, got);
        chk({got[0], st.read_req}, 2'b01);
        m.stretched = 1'b0;
        m.xfer({mdata, 1'b1}, got);
        chk({got[8:1], m.stretched}, {exp, 1'b1});
    endtask

    initial begin
        {i_reset_n, tm, hl, ev_clr} = 4'h0;
        sa = 10'h02a;
        tx_byte = 8'hc3;
        repeat (3) @(posedge i_core_clk);
        chk({scl_o, sda_o, scl_oe, sda_oe, tx_req, rx_valid, ev, st}, 16'h0000);
        repeat (2) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        foreach (rows[i]) run_row(rows[i]);
        // Data drops and rises with the clock high throughout
        clr_ev();
        m.blip();
        chk({ev_seen, st.bus_active}, 5'h11);
        read7(8'hff, 8'hc3);
        chk(ev_seen[3], 1'b1);
        // Master answers with a NACK on one byte; a second read then collides
        m.cond(1'b1);
        read7(8'h00, 8'h00);
        chk(ev_seen[0], 1'b1);
        m.cond(1'b1);
        @(posedge i_core_clk);
        tm <= 1'b1;
        sa <= 10'h2f1;
        tx_byte <= 8'h3c;
        clr_ev();
        m.cond(1'b0);
        m.xfer({8'hf4, 1'b1}, got);
        chk(got[0], 1'b0);
        m.xfer({8'hf1, 1'b1}, got);
        chk({got[0], st.write_req, st.ten_matched}, 3'h3);
        m.cond(1'b0);
        chk(ev_seen[2], 1'b1);
        m.xfer({8'hf5, 1'b1}, got);
        chk({got[0], st.read_req}, 2'b01);
        m.stretched = 1'b0;
        m.xfer({8'hff, 1'b1}, got);
        chk({got[8:1], m.stretched}, {8'h3c, 1'b1});
        m.cond(1'b1);
        chk(st, 4'h0);
        end_of_test();
    end
endmodule // test_i2c_bus_condition_detect

`default_nettype wire
